// ---- sdi_reclock_pkg.sv ----
// Constants, codes and timing counts shared by the reclocker control block.
package sdi_reclock_pkg;

  // ****************************************************************
  // Clocking and timing
  // ****************************************************************
  // The system clock and the reference are both whole MHz figures.
  // This lets the reference enable come from an exact phase accumulator.
  localparam int CLK_MHZ        = 100;
  localparam int REF_MHZ        = 27;
  localparam int REF_PERIOD_NS  = 37;
  localparam logic [6:0] REF_INC = 7'(REF_MHZ);
  localparam logic [6:0] REF_MOD = 7'(CLK_MHZ);

  // Longest time from a change on the serial input to lock being dropped.
  localparam int LOSS_TIME_US   = 1000;
  // Cycles spent after the timeout: reference enable wait and registers.
  localparam int LOSS_MARGIN    = 8;
  localparam int LOSS_CYCLES    = LOSS_TIME_US * CLK_MHZ - LOSS_MARGIN;
  localparam int LOSS_CNT_W     = 17;

  // Reference periods the loop must hold steady before lock is shown.
  localparam logic [3:0] SETTLE_TICKS = 4'hf;

  // ****************************************************************
  // Rate selection codes and detected rate classes
  // ****************************************************************
  localparam logic [1:0] RSEL_AUTO = 2'h0;
  localparam logic [1:0] RSEL_SD   = 2'h1;
  localparam logic [1:0] RSEL_HD   = 2'h2;
  localparam logic [1:0] RSEL_TEST = 2'h3;

  typedef enum logic [2:0] {
    DET_NONE = 3'b000,
    DET_143  = 3'b001,
    DET_270  = 3'b010,
    DET_1483 = 3'b011,
    DET_1485 = 3'b100,
    DET_177  = 3'b101,
    DET_360  = 3'b110,
    DET_540  = 3'b111
  } det_rate_t;

  typedef enum logic [1:0] {
    LK_IDLE   = 2'b00,
    LK_SETTLE = 2'b01,
    LK_LOCKED = 2'b10
  } lock_state_t;

  // ****************************************************************
  // Control pins: index in the synchroniser vector and pull levels
  // ****************************************************************
  localparam int PIN_RSEL0  = 0;
  localparam int PIN_RSEL1  = 1;
  localparam int PIN_MUTE_N = 2;
  localparam int PIN_BYPASS = 3;
  localparam int PIN_AUXSEL = 4;
  localparam int PIN_COUNT  = 5;
  // Only the active-low mute pin is pulled up; all others are pulled down.
  localparam logic [4:0] PIN_PULL = 5'h04;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 4;
  localparam logic [3:0]  REG_CTRL     = 4'h0;
  localparam logic [3:0]  REG_STATUS   = 4'h4;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam int CTRL_FORCE_MUTE   = 0;
  localparam int CTRL_FORCE_BYPASS = 1;
  localparam int ST_LOCK    = 0;
  localparam int ST_STD     = 1;
  localparam int ST_BYPASS  = 2;
  localparam int ST_MUTE    = 3;
  localparam int ST_TEST    = 4;
  localparam int ST_AUXCLK  = 5;
  localparam int ST_RSEL    = 8;
  localparam int ST_DET     = 12;

endpackage : sdi_reclock_pkg

// ---- ref_tick_gen.sv ----
// Reference-rate enable generator: one-cycle pulses at the reference rate.
`timescale 1ns/1ps
module ref_tick_gen (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      ref_tick_o
);

  logic [6:0] acc;
  logic [7:0] sum;
  logic       wrap;

  // ****************************************************************
  // Phase accumulator
  // ****************************************************************
  // Adds the reference figure each cycle; a wrap past the clock figure
  // marks one reference period, so the mean rate is exact.
  assign sum  = {1'b0, acc} + {1'b0, sdi_reclock_pkg::REF_INC};
  assign wrap = (sum >= {1'b0, sdi_reclock_pkg::REF_MOD});

  // Accumulator and registered tick.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc        <= 7'h00;
      ref_tick_o <= 1'b0;
    end else begin
      acc        <= wrap ? 7'(sum - {1'b0, sdi_reclock_pkg::REF_MOD}) : sum[6:0];
      ref_tick_o <= wrap;
    end
  end

endmodule : ref_tick_gen

// ---- sdi_reclocker_control.sv ----
// Control and indicator logic of a serial video reclocker with a Wishbone slave.
//
// Functional notes
// - Selection 00 means automatic rate detection; 143 Mbps accepted only there.
// - Selection 01 fixes the 270 Mbps rate, also for transport streams.
// - Both rate selection pins read low unless driven high.
// - The rate selection input can also put the device into test mode.
// - Transport streams at 270 Mbps retime; automatic mode accepts all supported rates.
// - Lock indicator high only with input data present and loop locked.
// - Mute input low silences all serial outputs, overriding bypass and lock.
// - Mute input reads high, outputs enabled, when undriven.
// - Bypass input high passes data unretimed, even when locked.
// - Bypass input low bypasses automatically when unlocked or rate unsupported.
// - Bypass input reads low when undriven: automatic bypass by default.
// - Rate flag high for 270 or 143 Mbps, low for HD rates.
// - Rate flag registered on the reference; forced low while unlocked.
// - Rate flag settles one reference period after lock changes.
// - A change on the serial input drops lock within 1 ms.
// - Aux select high gives recovered clock on aux output, low gives data.
// - Aux select reads low when undriven: aux carries second data copy.
// - Aux output muted when it carries clock and the device bypasses.
// - Never lock to 177, 360 or 540 Mbps; stay unlocked and bypass.
// - Lock acquired within 10 ms typical, 16 ms at most, automatic mode.
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module sdi_reclocker_control #(
  parameter int LOSS_CYCLES = sdi_reclock_pkg::LOSS_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Control pins: level and whether anything outside drives it.
  input  wire logic [1:0]  rate_sel_i,
  input  wire logic [1:0]  rate_sel_drv_i,
  input  wire logic        mute_n_i,
  input  wire logic        mute_n_drv_i,
  input  wire logic        bypass_i,
  input  wire logic        bypass_drv_i,
  input  wire logic        aux_clock_select_i,
  input  wire logic        aux_clock_select_drv_i,
  // Clock recovery loop and serial input.
  input  wire logic        pll_locked_i,
  input  wire logic [2:0]  detected_rate_i,
  input  wire logic        serial_video_in_i,
  input  wire logic        bit_strobe_i,
  input  wire logic        recovered_clk_i,
  // Serial outputs and indicators.
  output logic             primary_serial_out_o,
  output logic             aux_serial_out_o,
  output logic             primary_mute_o,
  output logic             aux_mute_o,
  output logic             reclock_bypass_o,
  output logic             lock_indicator_o,
  output logic             std_rate_flag_o,
  output logic             test_mode_o
);

  // ****************************************************************
  // Reference enable
  // ****************************************************************
  logic ref_tick;

  // Generated from the system clock at the 27 MHz reference rate, one pulse per reference period.
  ref_tick_gen u_ref_tick (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ref_tick_o (ref_tick)
  );

  // ****************************************************************
  // Control pins: pull resolution and synchronisers
  // ****************************************************************
  localparam int NP = sdi_reclock_pkg::PIN_COUNT;
  wire  [NP-1:0] pin_val;
  wire  [NP-1:0] pin_drv;
  wire  [NP-1:0] pin_level;
  logic [NP-1:0] sync_a;
  logic [NP-1:0] sync_b;
  logic [NP-1:0] pin_ref;

  assign pin_val = {aux_clock_select_i, bypass_i, mute_n_i, rate_sel_i};
  assign pin_drv = {aux_clock_select_drv_i, bypass_drv_i, mute_n_drv_i, rate_sel_drv_i};

  // An undriven pin takes its internal pull level.
  generate
    for (genvar p = 0; p < NP; p++) begin : g_pin
      assign pin_level[p] = pin_drv[p] ? pin_val[p] : sdi_reclock_pkg::PIN_PULL[p];

      // Two-stage synchroniser, then taken on the reference enable.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync_a[p]  <= sdi_reclock_pkg::PIN_PULL[p];
          sync_b[p]  <= sdi_reclock_pkg::PIN_PULL[p];
          pin_ref[p] <= sdi_reclock_pkg::PIN_PULL[p];
        end else begin
          sync_a[p] <= pin_level[p];
          sync_b[p] <= sync_a[p];
          if (ref_tick) begin
            pin_ref[p] <= sync_b[p];
          end
        end
      end
    end
  endgenerate

  wire [1:0] rate_sel;
  wire       mute_pin_n;
  wire       bypass_pin;
  wire       aux_clk_mode;

  assign rate_sel     = {pin_ref[sdi_reclock_pkg::PIN_RSEL1], pin_ref[sdi_reclock_pkg::PIN_RSEL0]};
  assign mute_pin_n   = pin_ref[sdi_reclock_pkg::PIN_MUTE_N];
  assign bypass_pin   = pin_ref[sdi_reclock_pkg::PIN_BYPASS];
  assign aux_clk_mode = pin_ref[sdi_reclock_pkg::PIN_AUXSEL];

  // ****************************************************************
  // Software control register
  // ****************************************************************
  logic [31:0] ctrl;
  wire         force_mute;
  wire         force_bypass;

  assign force_mute   = ctrl[sdi_reclock_pkg::CTRL_FORCE_MUTE];
  assign force_bypass = ctrl[sdi_reclock_pkg::CTRL_FORCE_BYPASS];

  // ****************************************************************
  // Rate acceptance
  // ****************************************************************
  sdi_reclock_pkg::det_rate_t det_rate;
  sdi_reclock_pkg::det_rate_t det_prev;
  logic rate_ok;
  logic rate_is_sd;

  assign det_rate = sdi_reclock_pkg::det_rate_t'(detected_rate_i);

  // Which detected rates the current selection accepts. Rates of 177,
  // 360 and 540 Mbps and an absent rate are never accepted.
  always_comb begin
    rate_ok = 1'b0;
    case (rate_sel)
      sdi_reclock_pkg::RSEL_AUTO: begin
        rate_ok = (det_rate == sdi_reclock_pkg::DET_143) ||
                  (det_rate == sdi_reclock_pkg::DET_270) ||
                  (det_rate == sdi_reclock_pkg::DET_1483) ||
                  (det_rate == sdi_reclock_pkg::DET_1485);
      end
      sdi_reclock_pkg::RSEL_SD: begin
        rate_ok = (det_rate == sdi_reclock_pkg::DET_270);
      end
      sdi_reclock_pkg::RSEL_HD, sdi_reclock_pkg::RSEL_TEST: begin
        rate_ok = (det_rate == sdi_reclock_pkg::DET_1483) ||
                  (det_rate == sdi_reclock_pkg::DET_1485);
      end
      default: begin
        rate_ok = 1'b0;
      end
    endcase
  end

  // Standard-definition class of the detected rate.
  assign rate_is_sd = (det_rate == sdi_reclock_pkg::DET_143) ||
                      (det_rate == sdi_reclock_pkg::DET_270);

  // Code 11 also raises the test mode indication.
  assign test_mode_o = (rate_sel == sdi_reclock_pkg::RSEL_TEST);

  // ****************************************************************
  // Signal presence
  // ****************************************************************
  logic                                   serial_prev;
  logic [sdi_reclock_pkg::LOSS_CNT_W-1:0] idle_cnt;
  wire                                    idle_max;
  wire                                    signal_present;

  assign idle_max       = (idle_cnt >= sdi_reclock_pkg::LOSS_CNT_W'(LOSS_CYCLES));
  assign signal_present = !idle_max;

  // Any transition restarts the count; a stalled input is lost in time
  // for lock to drop inside the longest allowed interval.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_prev <= 1'b0;
      idle_cnt    <= '0;
    end else begin
      serial_prev <= serial_video_in_i;
      if (serial_video_in_i != serial_prev) begin
        idle_cnt <= '0;
      end else if (!idle_max) begin
        idle_cnt <= idle_cnt + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Lock qualification
  // ****************************************************************
  sdi_reclock_pkg::lock_state_t lock_state;
  sdi_reclock_pkg::lock_state_t next_lock_state;
  logic [3:0] settle_cnt;
  logic [3:0] next_settle_cnt;
  wire        lock_good;
  wire        rate_changed;

  // Lock needs data, a locked loop and an accepted rate.
  assign lock_good    = pll_locked_i && signal_present && rate_ok;
  assign rate_changed = (det_rate != det_prev);

  // The settle wait is a few reference periods, far inside the
  // acquisition bound, so it only filters loop chatter.
  always_comb begin
    next_lock_state = lock_state;
    next_settle_cnt = settle_cnt;
    case (lock_state)
      sdi_reclock_pkg::LK_IDLE: begin
        next_settle_cnt = 4'h0;
        if (lock_good) begin
          next_lock_state = sdi_reclock_pkg::LK_SETTLE;
        end
      end
      sdi_reclock_pkg::LK_SETTLE: begin
        if (!lock_good || rate_changed) begin
          next_lock_state = sdi_reclock_pkg::LK_IDLE;
        end else if (settle_cnt == sdi_reclock_pkg::SETTLE_TICKS) begin
          next_lock_state = sdi_reclock_pkg::LK_LOCKED;
        end else begin
          next_settle_cnt = settle_cnt + 4'h1;
        end
      end
      sdi_reclock_pkg::LK_LOCKED: begin
        if (!lock_good || rate_changed) begin
          next_lock_state = sdi_reclock_pkg::LK_IDLE;
        end
      end
      default: begin
        next_lock_state = sdi_reclock_pkg::LK_IDLE;
      end
    endcase
  end

  // Lock state advances on the reference enable only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_state <= sdi_reclock_pkg::LK_IDLE;
      settle_cnt <= 4'h0;
      det_prev   <= sdi_reclock_pkg::DET_NONE;
    end else if (ref_tick) begin
      lock_state <= next_lock_state;
      settle_cnt <= next_settle_cnt;
      det_prev   <= det_rate;
    end
  end

  assign lock_indicator_o = (lock_state == sdi_reclock_pkg::LK_LOCKED);

  // ****************************************************************
  // Rate flag
  // ****************************************************************
  // Registered on the reference, so it follows lock one period later;
  // while unlocked it reads the HD level.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      std_rate_flag_o <= 1'b0;
    end else if (ref_tick) begin
      std_rate_flag_o <= lock_indicator_o && rate_is_sd;
    end
  end

  // ****************************************************************
  // Mute and bypass decisions
  // ****************************************************************
  wire muted;
  wire bypass;
  wire aux_muted;

  // Mute overrides everything.
  assign muted  = !mute_pin_n || force_mute;
  // Forced bypass, or automatic bypass whenever not locked.
  assign bypass = bypass_pin || force_bypass || !lock_indicator_o;
  // In clock mode the aux output also goes quiet in bypass.
  assign aux_muted = muted || (aux_clk_mode && bypass);

  assign primary_mute_o   = muted;
  assign aux_mute_o       = aux_muted;
  assign reclock_bypass_o = bypass;

  // ****************************************************************
  // Serial data path
  // ****************************************************************
  logic retimed;

  // Retiming samples the input at the recovered bit centre.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      retimed <= 1'b0;
    end else if (bit_strobe_i) begin
      retimed <= serial_video_in_i;
    end
  end

  wire data_sel;

  // Bypass hands the raw input through; otherwise retimed data.
  assign data_sel = bypass ? serial_video_in_i : retimed;

  // Output registers; a muted output rests low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_serial_out_o <= 1'b0;
      aux_serial_out_o     <= 1'b0;
    end else begin
      primary_serial_out_o <= muted ? 1'b0 : data_sel;
      if (aux_muted) begin
        aux_serial_out_o <= 1'b0;
      end else begin
        aux_serial_out_o <= aux_clk_mode ? recovered_clk_i : data_sel;
      end
    end
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  wire        wb_hit;
  wire        sel_ctrl;
  wire        sel_status;
  wire [31:0] status_word;
  wire [31:0] rd_word;

  assign wb_hit     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign sel_ctrl   = (wb_adr_i == sdi_reclock_pkg::REG_CTRL);
  assign sel_status = (wb_adr_i == sdi_reclock_pkg::REG_STATUS);

  // Status gathers the block's live state; unused bits read zero.
  assign status_word = {17'h0_0000,
                        det_rate,
                        2'h0,
                        rate_sel,
                        2'h0,
                        aux_clk_mode,
                        test_mode_o,
                        muted,
                        bypass,
                        std_rate_flag_o,
                        lock_indicator_o};

  assign rd_word = sel_ctrl   ? ctrl :
                   sel_status ? status_word : 32'h0000_0000;

  // One wait state: ack a cycle after the request, then drop it. Writes
  // to the low byte of the control word land on the acked edge only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= (wb_hit && !wb_we_i) ? rd_word : 32'h0000_0000;
    end
  end

  // Control word update.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= sdi_reclock_pkg::CTRL_RESET;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && sel_ctrl && wb_sel_i[0]) begin
      ctrl <= {30'h0000_0000, wb_dat_i[1:0]};
    end
  end

endmodule : sdi_reclocker_control

// ---- sdi_reclock_assertions.sv ----
// Concurrent checks on the ports of the reclocker control block.
`timescale 1ns/1ps
module sdi_reclock_assertions (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic serial_video_in_i,
  input wire logic pll_locked_i,
  input wire logic primary_serial_out_o,
  input wire logic aux_serial_out_o,
  input wire logic primary_mute_o,
  input wire logic aux_mute_o,
  input wire logic reclock_bypass_o,
  input wire logic lock_indicator_o,
  input wire logic std_rate_flag_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // **********
  // Bus handshake
  // **********
  // A request that is taken must be answered on the very next edge.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_bus_ack_next: assert property (s_req |=> wb_ack_o) else $error("request not answered");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  // **********
  // Outputs, lock and rate flag
  // **********
  // Mute has to win over bypass, so both outputs are checked one cycle on.
  a_mute_outputs: assert property (primary_mute_o |=> !primary_serial_out_o && !aux_serial_out_o) else $error("muted output moved");
  a_mute_covers_aux: assert property (primary_mute_o |-> aux_mute_o) else $error("aux not muted");
  a_aux_mute_quiet: assert property (aux_mute_o |=> !aux_serial_out_o) else $error("muted aux moved");
  a_unlock_bypass: assert property (!lock_indicator_o |-> reclock_bypass_o) else $error("retiming while unlocked");
  a_bypass_pass: assert property (reclock_bypass_o && !primary_mute_o |=> primary_serial_out_o == $past(serial_video_in_i)) else $error("bypass data wrong");
  a_flag_needs_lock: assert property (!lock_indicator_o [*6] |-> !std_rate_flag_o) else $error("flag high unlocked");
  a_lock_needs_pll: assert property (!pll_locked_i [*6] |-> !lock_indicator_o) else $error("lock without loop");
  a_flag_after_fall: assert property ($fell(lock_indicator_o) |-> ##[1:6] !std_rate_flag_o) else $error("flag slow to fall");
endmodule : sdi_reclock_assertions

bind sdi_reclocker_control sdi_reclock_assertions u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .serial_video_in_i(serial_video_in_i), .pll_locked_i(pll_locked_i),
  .primary_serial_out_o(primary_serial_out_o), .aux_serial_out_o(aux_serial_out_o),
  .primary_mute_o(primary_mute_o), .aux_mute_o(aux_mute_o), .reclock_bypass_o(reclock_bypass_o),
  .lock_indicator_o(lock_indicator_o), .std_rate_flag_o(std_rate_flag_o)
);

// ---- sdi_source_model.sv ----
// Model of the serial source and the clock recovery loop that feed the block.
`timescale 1ns/1ps
module sdi_source_model #(
  parameter int LOCK_WAIT = 12
) (
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic       stall_i,
  input  wire logic [2:0] rate_i,
  output logic            data_o,
  output logic            strobe_o,
  output logic            rclk_o,
  output logic            locked_o,
  output logic [2:0]      rate_o
);
  logic [7:0] lfsr = 8'h5a;
  int         cnt  = 0;
  // **********
  // Loop and line
  // **********
  // The loop reports lock only after a steady spell, and drops it at once on loss or rate change.
  always @(posedge clk_i) begin
    rate_o <= run_i ? rate_i : 3'h0;
    cnt <= (!run_i || rate_i != rate_o) ? 0 : (cnt < LOCK_WAIT ? cnt + 1 : cnt);
    locked_o <= run_i && rate_i == rate_o && cnt >= LOCK_WAIT;
    rclk_o <= run_i ? !rclk_o : 1'b0;
    strobe_o <= run_i && !strobe_o;
    // A stalled source holds its line and an absent one drives it low, so no transitions reach the block.
    if (run_i && !stall_i && strobe_o) begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      data_o <= lfsr[7];
    end else if (!run_i) begin
      data_o <= 1'b0;
    end
  end
endmodule : sdi_source_model

// ---- tb_top.sv ----
// Self-checking bench for the reclocker control block.
`timescale 1ns/1ps
module tb_top;
  logic        clk_i, rst_i, cyc, stb, we, ack, mn, mn_d, byp, byp_d, aux, aux_d, tie;
  logic        run, stall, svi, bstb, rclk, pll, pso, aso, pmo, amo, rbo, lock, flag, tmo;
  logic [1:0]  rs, rs_d;
  logic [2:0]  rate, det;
  logic [3:0]  adr, sel;
  logic [31:0] wd, rd_o, rd;
  int          err_count, comparisons;
  // Cases: rate select [6:5], detected rate [4:2], lock expected [1], rate flag expected [0].
  localparam logic [6:0] CASES [9] = '{7'h07, 7'h2b, 7'h52, 7'h6e, 7'h0b, 7'h24, 7'h14, 7'h18, 7'h1c};

  sdi_reclocker_control #(.LOSS_CYCLES(200)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd_o), .wb_ack_o(ack), .rate_sel_i(rs),
    .rate_sel_drv_i(rs_d), .mute_n_i(mn), .mute_n_drv_i(mn_d), .bypass_i(byp), .bypass_drv_i(byp_d),
    .aux_clock_select_i(aux), .aux_clock_select_drv_i(aux_d), .pll_locked_i(pll),
    .detected_rate_i(det), .serial_video_in_i(svi), .bit_strobe_i(bstb), .recovered_clk_i(rclk),
    .primary_serial_out_o(pso), .aux_serial_out_o(aso), .primary_mute_o(pmo), .aux_mute_o(amo),
    .reclock_bypass_o(rbo), .lock_indicator_o(lock), .std_rate_flag_o(flag), .test_mode_o(tmo));
  sdi_source_model u_src (.clk_i(clk_i), .run_i(run), .stall_i(stall), .rate_i(rate),
    .data_o(svi), .strobe_o(bstb), .rclk_o(rclk), .locked_o(pll), .rate_o(det));

  // **********
  // Clock, board loop-back and watchdog
  // **********
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Board option that feeds the lock indicator back into the mute pin.
  always @(posedge clk_i) if (tie) mn <= lock;
  // The tests need about 2.5k cycles; 50k leaves room without hiding a hang.
  initial begin
    #500_000;
    err_count++;
    tally_and_finish();
  end

  // **********
  // Helpers
  // **********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // Pin levels with their drive flags; an undriven pin must read as its pull level.
  task automatic pins(input logic [1:0] r, input logic [1:0] rd_, input logic m, input logic md,
                      input logic b, input logic bd, input logic x, input logic xd);
    rs <= r;
    rs_d <= rd_;
    mn <= m;
    mn_d <= md;
    byp <= b;
    byp_d <= bd;
    aux <= x;
    aux_d <= xd;
  endtask : pins
  task automatic src(input logic r, input logic s, input logic [2:0] k);
    run <= r;
    stall <= s;
    rate <= k;
  endtask : src
  // One classic cycle; the request stands until ack is seen, then one idle cycle.
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wd <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    chk(ack, 1'b0);
  endtask : bus
  task automatic wait_lock(input logic v, input int max, output int n);
    n = 0;
    while (lock !== v && n < max) begin
      @(posedge clk_i);
      n++;
    end
  endtask : wait_lock

  // **********
  // Scenarios
  // **********
  task automatic t_pulls();
    pins(2'h3, 2'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    tick(12);
    bus(1'b0, 4'h4, 4'hf, 32'h0000_0000);
    chk(rd & 32'h0000_033c, 32'h0000_0004);
    chk({lock, flag, pmo}, 3'h0);
  endtask : t_pulls
  task automatic t_rates();
    logic [6:0] c;
    int         n;
    for (int i = 0; i < 9; i++) begin
      c = CASES[i];
      src(1'b0, 1'b0, 3'h0);
      tick(8);
      pins(c[6:5], 2'h3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
      src(1'b1, 1'b0, c[4:2]);
      wait_lock(1'b1, 300, n);
      tick(8);
      chk(lock, c[1]);
      chk(rbo, !c[1]);
      chk(flag, c[0]);
      chk(tmo, c[6] & c[5]);
    end
  endtask : t_rates
  task automatic t_loss();
    int n;
    pins(2'h0, 2'h3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    src(1'b1, 1'b0, 3'h2);
    wait_lock(1'b1, 300, n);
    src(1'b1, 1'b1, 3'h2);
    wait_lock(1'b0, 400, n);
    chk(n > 150 && n < 260, 1'b1);
    tick(6);
    chk(flag, 1'b0);
    src(1'b1, 1'b0, 3'h2);
    wait_lock(1'b1, 300, n);
  endtask : t_loss
  task automatic t_ctrl();
    logic p;
    pins(2'h0, 2'h3, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    tick(10);
    chk(rbo, 1'b0);
    for (int i = 0; i < 8; i++) begin
      p = rclk;
      @(posedge clk_i);
      chk(aso, p);
    end
    pins(2'h0, 2'h3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    tick(10);
    chk({lock, rbo}, 2'h3);
    for (int i = 0; i < 8; i++) begin
      p = svi;
      @(posedge clk_i);
      chk({pso, aso}, {p, p});
    end
    pins(2'h0, 2'h3, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    tick(10);
    chk({amo, pmo, aso}, 3'h4);
    pins(2'h0, 2'h3, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    tick(10);
    chk({pmo, pso, aso}, 3'h4);
    pins(2'h0, 2'h3, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    tick(10);
  endtask : t_ctrl
  task automatic t_tie();
    int n;
    tie <= 1'b1;
    src(1'b0, 1'b0, 3'h2);
    tick(30);
    chk(pmo, 1'b1);
    src(1'b1, 1'b0, 3'h2);
    wait_lock(1'b1, 300, n);
    tick(10);
    chk(pmo, 1'b0);
    tie <= 1'b0;
  endtask : t_tie
  // Force mute from software, a write with lane 0 off, a status write, an unmapped read.
  task automatic t_bus();
    bus(1'b1, 4'h0, 4'hf, 32'h0000_0001);
    tick(8);
    chk(pmo, 1'b1);
    bus(1'b1, 4'h0, 4'h0, 32'h0000_0002);
    bus(1'b0, 4'h0, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    bus(1'b1, 4'h4, 4'hf, 32'hffff_ffff);
    bus(1'b1, 4'h0, 4'hf, 32'h0000_0000);
    bus(1'b0, 4'h8, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    tick(8);
    bus(1'b0, 4'h4, 4'hf, 32'h0000_0000);
    chk(rd[3:0], 4'h3);
  endtask : t_bus

  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial begin
    err_count = 0;
    comparisons = 0;
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, wd, tie} = '0;
    {rs, rs_d, mn_d, byp, byp_d, aux, aux_d, run, stall, rate} = '0;
    mn = 1'b1;
    tick(4);
    rst_i <= 1'b0;
    t_pulls();
    t_rates();
    t_loss();
    t_ctrl();
    t_tie();
    t_bus();
    tally_and_finish();
  end
endmodule : tb_top
